// ===== logic/pcs_pkg.sv
// package: constants for the program counter sequencer
package pcs_pkg;
    // ========================================
    // address space and vectors
    localparam int PC_WIDTH = 13;
    localparam int WORD_WIDTH = 14;
    localparam int SMALL_DEPTH = 1024;
    localparam int LARGE_DEPTH = 2048;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    // ========================================
    // return stack and clocking
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;
    localparam int OSC_PER_CYCLE = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] PHASE_HALF = 2'h2;
    // ========================================
    // flow commands from the instruction decoder
    typedef enum logic [2:0] {
        pcs_op_next,
        pcs_op_jump,
        pcs_op_call,
        pcs_op_ret,
        pcs_op_skip
    } pcs_op_t;
endpackage

// ===== logic/pcs_stack.sv
// eight-level return address stack, circular with no overflow flag
`timescale 1ns/1ps
`default_nettype none
module pcs_stack #(
    parameter int DEPTH = pcs_pkg::STACK_DEPTH,
    parameter int PW = pcs_pkg::STACK_PTR_W,
    parameter int AW = pcs_pkg::PC_WIDTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // push and pop
    input wire logic push,
    input wire logic pop,
    input wire logic [AW-1:0] push_addr,
    output logic [AW-1:0] top_addr
);
    logic [AW-1:0] mem [DEPTH];
    logic [PW-1:0] ptr;
    wire [PW-1:0] top_idx = ptr - {{(PW-1){1'b0}}, 1'b1};

    // pointer wraps silently; a ninth push overwrites the oldest entry
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ptr <= '0;
        end else if (push) begin
            ptr <= ptr + {{(PW-1){1'b0}}, 1'b1}; // RQ10
        end else if (pop) begin
            ptr <= top_idx; // RQ10
        end
    end

    // storage has no reset, as in a real register file
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[ptr] <= push_addr; // RQ6
        end
    end

    assign top_addr = mem[top_idx];

    chk_push_then_pop: assert property (@(posedge mclk) disable iff (!nrst)
        push && !pop |=> top_addr == $past(push_addr)) // RQ6
        else $error("popped address differs from pushed one");
endmodule
`default_nettype wire

// ===== logic/pcs_core.sv
// program counter sequencer: pc, fetch address, vectors, stack, instruction_rate_clock_out
// ========================================
// How it works
// [RQ1] program counter is 13 bits, spanning 8K words of 14 bits.
// [RQ2] implemented store is 1K words small or 2K words large variant.
// [RQ3] addresses above implemented store wrap onto implemented words.
// [RQ4] reset loads pc with 0000h; taken interrupt jumps to 0004h.
// [RQ5] program fetch bus is separate from the data memory bus.
// [RQ6] hardware return stack holds eight pc values.
// [RQ7] one cycle per instruction; flow changes take two cycles.
// [RQ8] clock output runs at a quarter of the oscillator, per cycle.
// [RQ9] outside circuit holds master reset low to reset, high to run.
// [RQ10] push on call or interrupt, pop on return, no overflow flag.
`timescale 1ns/1ps
`default_nettype none
module pcs_core #(
    parameter int MEM_DEPTH = pcs_pkg::LARGE_DEPTH,
    parameter int AW = pcs_pkg::PC_WIDTH,
    parameter int DW = pcs_pkg::WORD_WIDTH
) (
    // clock (oscillator input) and reset
    input wire logic mclk,
    input wire logic nrst,
    input wire logic master_reset_n,
    // decoder command, sampled on the last phase of a cycle
    input wire logic [2:0] flow_op,
    input wire logic [AW-1:0] flow_target,
    input wire logic irq_req,
    // program memory bus
    output logic [AW-1:0] prog_addr,
    input wire logic [DW-1:0] prog_data,
    output logic [DW-1:0] instr,
    output logic instr_valid,
    // status
    output logic [AW-1:0] pc,
    output logic cycle_end,
    output logic in_flush,
    output logic instruction_rate_clock_out
);
    localparam int IW = $clog2(MEM_DEPTH); // RQ2

    // ========================================
    // master reset pin synchroniser
    logic mr_meta, mr_sync;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mr_meta <= 1'b0;
            mr_sync <= 1'b0;
        end else begin
            mr_meta <= master_reset_n;
            mr_sync <= mr_meta; // RQ9
        end
    end
    wire run = mr_sync;

    // ========================================
    // four oscillator phases make one instruction cycle
    logic [1:0] phase;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase <= 2'h0;
        end else if (!run) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    assign cycle_end = run && (phase == pcs_pkg::PHASE_LAST);

    // clock output low in the first half, high in the second
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            instruction_rate_clock_out <= 1'b0;
        end else begin
            instruction_rate_clock_out <= run &&
                (phase + 2'h1 >= pcs_pkg::PHASE_HALF); // RQ8
        end
    end

    // ========================================
    // next pc selection
    logic flush;
    logic [AW-1:0] stack_top;
    wire pcs_pkg::pcs_op_t op = pcs_pkg::pcs_op_t'(flow_op);
    wire take_irq = irq_req && !flush;
    wire do_call = !flush && !irq_req && op == pcs_pkg::pcs_op_call;
    wire do_ret = !flush && !irq_req && op == pcs_pkg::pcs_op_ret;
    wire do_jump = !flush && !irq_req && op == pcs_pkg::pcs_op_jump;
    wire do_skip = !flush && !irq_req && op == pcs_pkg::pcs_op_skip;
    wire redirect = take_irq || do_call || do_ret || do_jump || do_skip;
    wire [AW-1:0] pc_inc = pc + {{(AW-1){1'b0}}, 1'b1};
    logic [AW-1:0] next_pc;

    // interrupt wins over decoder; a flush cycle only advances
    always_comb begin
        next_pc = pc_inc;
        if (take_irq) begin
            next_pc = pcs_pkg::IRQ_VECTOR; // RQ4
        end else if (do_call || do_jump) begin
            next_pc = flow_target;
        end else if (do_ret) begin
            next_pc = stack_top;
        end
    end

    // skip discards the fetched word, which also costs a second cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pc <= pcs_pkg::RESET_VECTOR;
            flush <= 1'b1;
        end else if (!run) begin
            pc <= pcs_pkg::RESET_VECTOR; // RQ4
            flush <= 1'b1;
        end else if (cycle_end) begin
            pc <= next_pc; // RQ1
            flush <= redirect; // RQ7
        end
    end

    // return address: the word fetched now is discarded, so it is the
    // one to resume at, for a call and an interrupt alike
    wire [AW-1:0] ret_addr = pc;
    pcs_stack #(
        .DEPTH(pcs_pkg::STACK_DEPTH),
        .PW(pcs_pkg::STACK_PTR_W),
        .AW(AW)
    ) u_stack (
        .mclk(mclk),
        .nrst(nrst),
        .push(cycle_end && (take_irq || do_call)), // RQ10
        .pop(cycle_end && do_ret), // RQ10
        .push_addr(ret_addr),
        .top_addr(stack_top)
    );

    // ========================================
    // fetch bus: high bits dropped so access wraps
    assign prog_addr = {{(AW-IW){1'b0}}, pc[IW-1:0]}; // RQ3

    // dedicated fetch latch, no shared data path; a word fetched in a
    // redirecting cycle is dropped, so the target word is the one run
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            instr <= '0;
            instr_valid <= 1'b0;
        end else begin
            if (cycle_end) begin
                instr <= prog_data; // RQ5
            end
            instr_valid <= cycle_end && !redirect; // RQ7
        end
    end

    // status straight from the flush flop, no extra clock of lag
    assign in_flush = flush; // RQ7

    // ========================================
    // checks
    chk_fetch_wraps: assert property (@(posedge mclk) disable iff (!nrst)
        prog_addr < AW'(MEM_DEPTH) && prog_addr[IW-1:0] == pc[IW-1:0]) // RQ3
        else $error("fetch address outside implemented store");
    chk_reset_vector: assert property (@(posedge mclk) disable iff (!nrst)
        !run |=> pc == pcs_pkg::RESET_VECTOR) // RQ4
        else $error("pc not at reset vector");
    chk_irq_vector: assert property (@(posedge mclk) disable iff (!nrst)
        cycle_end && take_irq |=> pc == pcs_pkg::IRQ_VECTOR && flush) // RQ4
        else $error("interrupt did not vector to 0004h");
    chk_cycle_len: assert property (@(posedge mclk) disable iff (!nrst)
        cycle_end |=> !cycle_end [*3] ##1 (cycle_end || !run)) // RQ8
        else $error("instruction cycle is not four clocks");
    chk_instruction_rate_clock_out_duty: assert property (@(posedge mclk) disable iff (!nrst)
        cycle_end |=> !instruction_rate_clock_out
            ##1 !instruction_rate_clock_out) // RQ8
        else $error("clock output low half wrong");
    chk_instruction_rate_clock_out_high: assert property (@(posedge mclk) disable iff (!nrst)
        cycle_end |-> instruction_rate_clock_out) // RQ8
        else $error("clock output not high at cycle end");
    chk_two_cycle: assert property (@(posedge mclk) disable iff (!nrst)
        cycle_end && redirect |=> (flush && !instr_valid) [*4]) // RQ7
        else $error("flow change not given a dead cycle");
    chk_one_cycle: assert property (@(posedge mclk) disable iff (!nrst)
        cycle_end && !redirect |=> instr_valid) // RQ7
        else $error("ordinary cycle produced no instruction");
    chk_pc_step: assert property (@(posedge mclk) disable iff (!nrst)
        cycle_end && run && !redirect |=> pc == $past(pc_inc)) // RQ1
        else $error("pc did not step by one");
    chk_call_ret: assert property (@(posedge mclk) disable iff (!nrst)
        cycle_end && do_ret |=> pc == $past(stack_top)) // RQ10
        else $error("return did not load stacked address");
    chk_fetch_latch: assert property (@(posedge mclk) disable iff (!nrst)
        cycle_end |=> instr == $past(prog_data)) // RQ5
        else $error("fetched word not captured");
    chk_sync_reset: assert property (@(posedge mclk) disable iff (!nrst)
        !master_reset_n ##1 1 |=> !run) // RQ9
        else $error("master reset not seen after two clocks");

    cov_irq: cover property (@(posedge mclk) cycle_end && take_irq);
    cov_call: cover property (@(posedge mclk) cycle_end && do_call);
    cov_ret: cover property (@(posedge mclk) cycle_end && do_ret);
    cov_wrap: cover property (@(posedge mclk) pc >= AW'(MEM_DEPTH));
endmodule
`default_nettype wire

// ===== testbench/pcs_prog_mem.sv
// program memory model on the sequencer's fetch bus
`timescale 1ns/1ps
`default_nettype none
module pcs_prog_mem #(
    parameter int DEPTH = pcs_pkg::LARGE_DEPTH
) (
    // fetch bus
    input wire logic [12:0] prog_addr,
    output logic [13:0] prog_data
);
    logic [13:0] mem [DEPTH];
    // each word encodes its own address so a wrong fetch shows at once
    initial begin
        for (int a = 0; a < DEPTH; a++) begin
            mem[a] = {1'b1, a[12:0]} ^ 14'h0155;
        end
    end
    // own bus, no data traffic; reads beyond DEPTH give unknown words
    assign prog_data = mem[prog_addr];
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the program counter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    // small variant, so fetches above 03ffh must fold back
    localparam int DEPTH = pcs_pkg::SMALL_DEPTH;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic master_reset_n = 1'b1;
    logic [2:0] flow_op = 3'h0;
    logic [12:0] flow_target = 13'h0000;
    logic irq_req = 1'b0;
    logic [12:0] prog_addr, pc, p;
    logic [13:0] prog_data, instr;
    logic instr_valid, cycle_end, in_flush, clk_out;
    logic [12:0] ret_q[$];
    int failures = 0;
    int n_checks = 0;
    int n_valid = 0;
    int v;

    pcs_core #(.MEM_DEPTH(DEPTH)) DUT (
        .mclk(mclk), .nrst(nrst), .master_reset_n(master_reset_n),
        .flow_op(flow_op), .flow_target(flow_target), .irq_req(irq_req),
        .prog_addr(prog_addr), .prog_data(prog_data), .instr(instr),
        .instr_valid(instr_valid), .pc(pc), .cycle_end(cycle_end),
        .in_flush(in_flush), .instruction_rate_clock_out(clk_out)
    );
    pcs_prog_mem #(.DEPTH(DEPTH)) mem (
        .prog_addr(prog_addr), .prog_data(prog_data)
    );

    // ========================================
    // clock, pulse counter and helpers
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) n_valid <= n_valid + int'(instr_valid);

    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    // one instruction cycle: wait for its last phase, then present a command
    task automatic cyc(input logic [2:0] op, input logic [12:0] tgt,
                       input logic irq);
        int i;
        i = 0;
        while (cycle_end !== 1'b1 && i < 16) begin
            @(negedge mclk);
            i++;
        end
        chk({13'h0000, cycle_end}, 14'h0001);
        flow_op = op;
        flow_target = tgt;
        irq_req = irq;
        @(negedge mclk);
        flow_op = 3'h0;
        irq_req = 1'b0;
    endtask
    task automatic nxt();
        cyc(3'h0, 13'h0000, 1'b0);
    endtask

    // ========================================
    // scenarios
    task automatic s_reset();
        chk(pc, 13'h0000);
        chk(clk_out, 1'b0);
        nxt();
        chk(pc, 13'h0001);
        chk(instr_valid, 1'b1);
        chk(instr, {1'b1, 13'h0000} ^ 14'h0155);
    endtask
    // four plain cycles: four words, four clocks per cycle
    task automatic s_seq();
        nxt();
        p = pc;
        v = n_valid;
        repeat (4) nxt();
        chk(pc, p + 13'h0004);
        chk(14'(n_valid - v), 14'h0004);
        for (int k = 0; k < 8; k++) begin
            chk(clk_out, k % 4 >= 2);
            chk(cycle_end, k % 4 == 3);
            if (k == 0) chk(instr, {1'b1, p + 13'h0003} ^ 14'h0155);
            @(negedge mclk);
        end
    endtask
    // jump high, command in flush cycle ignored, pc rolls over 13 bits
    task automatic s_jump();
        cyc(pcs_pkg::pcs_op_jump, 13'h1ffe, 1'b0);
        chk(pc, 13'h1ffe);
        chk(prog_addr, 13'h03fe);
        chk(in_flush, 1'b1);
        chk(instr_valid, 1'b0);
        cyc(pcs_pkg::pcs_op_call, 13'h0123, 1'b0);
        chk(pc, 13'h1fff);
        chk(instr_valid, 1'b1);
        chk(instr, {1'b1, 13'h03fe} ^ 14'h0155);
        nxt();
        chk(pc, 13'h0000);
    endtask
    // nine nested calls: the ninth overwrites the oldest slot
    task automatic s_stack();
        for (int k = 0; k < 9; k++) begin
            ret_q.push_back(pc);
            cyc(pcs_pkg::pcs_op_call, 13'h0100 + 13'(k * 16), 1'b0);
            chk(pc, 13'h0100 + 13'(k * 16));
            nxt();
        end
        for (int k = 0; k < 8; k++) begin
            cyc(pcs_pkg::pcs_op_ret, 13'h0000, 1'b0);
            chk(pc, ret_q.pop_back());
            nxt();
        end
    endtask
    // interrupt beats a jump and returns to the interrupted address
    task automatic s_irq();
        p = pc;
        cyc(pcs_pkg::pcs_op_jump, 13'h0555, 1'b1);
        chk(pc, pcs_pkg::IRQ_VECTOR);
        chk(instr_valid, 1'b0);
        nxt();
        chk(instr_valid, 1'b1);
        chk(instr, {1'b1, 13'h0004} ^ 14'h0155);
        cyc(pcs_pkg::pcs_op_ret, 13'h0000, 1'b0);
        chk(pc, p);
    endtask
    // skip drops the word fetched with it and costs a second cycle
    task automatic s_skip();
        nxt();
        p = pc;
        cyc(pcs_pkg::pcs_op_skip, 13'h0000, 1'b0);
        chk(pc, p + 13'h0001);
        chk(instr_valid, 1'b0);
        chk(in_flush, 1'b1);
        nxt();
        chk(pc, p + 13'h0002);
        chk(instr_valid, 1'b1);
        chk(instr, {1'b1, p + 13'h0001} ^ 14'h0155);
    endtask
    task automatic s_mreset();
        master_reset_n = 1'b0;
        repeat (5) @(negedge mclk);
        chk(pc, 13'h0000);
        chk(clk_out, 1'b0);
        master_reset_n = 1'b1;
        nxt();
        chk(pc, 13'h0001);
    endtask

    // ========================================
    // verdict, main sequence and watchdog
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        nrst = 1'b1;
        s_reset();
        s_seq();
        s_jump();
        s_stack();
        s_irq();
        s_skip();
        s_mreset();
        end_sim();
    end
    initial begin
        #100000;
        failures++;
        end_sim();
    end
endmodule
`default_nettype wire
